// ### rtl/ppl_probe_latch.sv
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ppl_probe_latch
  import ppl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        probe_input_one_in,
  input  wire logic        probe_input_two_in,
  input  wire logic [31:0] position_in,
  input  wire logic [1:0]  enc_pulse_in,
  output logic      [1:0]  enc_pulse_out,
  output logic             irq_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]      ctrl_reg, ctrl_next;
  logic             prec_reg, prec_next;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic             ack_reg, ack_next;
  logic [1:0]       enc_reg, enc_next;
  logic [31:0]      wmerged, rd_mux;
  logic             rd_take;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Probe synchroniser and sampling ticks
  // ----------------------------------------------------------------
  logic [1:0]        probe_sync;
  logic [TICK_W-1:0] norm_cnt_reg, norm_cnt_next;
  logic [TICK_W-1:0] fine_cnt_reg, fine_cnt_next;
  logic              normal_tick, fine_tick, p2_rise_tick;

  ppl_sync #(
    .W (2)
  ) u_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  ({probe_input_two_in, probe_input_one_in}),
    .sync_out  (probe_sync)
  );

  always_comb begin
    normal_tick   = (norm_cnt_reg == TICK_W'(NORMAL_TICK_CYC - 1));
    fine_tick     = (fine_cnt_reg == TICK_W'(FINE_TICK_CYC - 1));
    norm_cnt_next = normal_tick ? '0 : norm_cnt_reg + 1'b1;
    fine_cnt_next = fine_tick ? '0 : fine_cnt_reg + 1'b1;
    // Only the rising edge of probe two gets the fine rate
    p2_rise_tick  = prec_reg ? fine_tick : normal_tick;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      norm_cnt_reg <= '0;
      fine_cnt_reg <= '0;
    end else begin
      norm_cnt_reg <= norm_cnt_next;
      fine_cnt_reg <= fine_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Probe channels
  // ----------------------------------------------------------------
  ppl_ctrl_type ctrl1, ctrl2;
  ppl_stat_type stat1, stat2;
  ppl_pos_type  pos1, pos2;
  logic         r_evt1, f_evt1, r_evt2, f_evt2;

  assign ctrl1 = ppl_ctrl_type'(ctrl_reg[5:0]);
  assign ctrl2 = ppl_ctrl_type'(ctrl_reg[PROBE_TWO_LSB +: 6]);

  ppl_probe_chan u_chan1 (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .ctrl_in      (ctrl1),
    .probe_lvl_in (probe_sync[0]),
    .rise_tick_in (normal_tick),
    .fall_tick_in (normal_tick),
    .position_in  (position_in),
    .stat_out     (stat1),
    .pos_out      (pos1),
    .rise_evt_out (r_evt1),
    .fall_evt_out (f_evt1)
  );

  ppl_probe_chan u_chan2 (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .ctrl_in      (ctrl2),
    .probe_lvl_in (probe_sync[1]),
    .rise_tick_in (p2_rise_tick),
    .fall_tick_in (normal_tick),
    .position_in  (position_in),
    .stat_out     (stat2),
    .pos_out      (pos2),
    .rise_evt_out (r_evt2),
    .fall_evt_out (f_evt2)
  );

  // ----------------------------------------------------------------
  // Avalon slave: writes in zero waits, reads in one
  // ----------------------------------------------------------------
  always_comb begin
    wmerged = '0;
    rd_take = avs_read_in & ~ack_reg;
    rd_mux  = 32'h0000_0000;
    case (avs_address_in)
      OFS_CTRL: begin
        rd_mux  = {16'h0000, ctrl_reg};
        wmerged = be_merge({16'h0000, ctrl_reg}, avs_writedata_in, avs_byteenable_in);
      end
      OFS_STATUS: begin
        rd_mux = {16'h0000, 5'h00, stat2, 5'h00, stat1};
      end
      OFS_POS1_R: begin
        rd_mux = pos1.rise_pos;
      end
      OFS_POS1_F: begin
        rd_mux = pos1.fall_pos;
      end
      OFS_POS2_R: begin
        rd_mux = pos2.rise_pos;
      end
      OFS_POS2_F: begin
        rd_mux = pos2.fall_pos;
      end
      OFS_CONFIG: begin
        rd_mux  = {31'h0000_0000, prec_reg};
        wmerged = be_merge({31'h0000_0000, prec_reg}, avs_writedata_in, avs_byteenable_in);
      end
      OFS_IRQ_STAT: begin
        rd_mux  = {28'h000_0000, irq_stat_reg};
        wmerged = be_merge(32'h0000_0000, avs_writedata_in, avs_byteenable_in);
      end
      OFS_IRQ_MASK: begin
        rd_mux  = {28'h000_0000, irq_mask_reg};
        wmerged = be_merge({28'h000_0000, irq_mask_reg}, avs_writedata_in, avs_byteenable_in);
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    ctrl_next     = ctrl_reg;
    prec_next     = prec_reg;
    irq_mask_next = irq_mask_reg;
    // Reserved control bits stay zero whatever software writes
    if (avs_write_in && avs_address_in == OFS_CTRL) begin
      ctrl_next = wmerged[15:0] & CTRL_WMASK;
    end
    if (avs_write_in && avs_address_in == OFS_CONFIG) begin
      prec_next = wmerged[CFG_PREC_BIT];
    end
    if (avs_write_in && avs_address_in == OFS_IRQ_MASK) begin
      irq_mask_next = wmerged[IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_reg;
    if (avs_write_in && avs_address_in == OFS_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~wmerged[IRQ_W-1:0];
    end
    // A capture in the clearing cycle still sets its bit
    irq_stat_next[IRQ_P1_RISE] = irq_stat_next[IRQ_P1_RISE] | r_evt1;
    irq_stat_next[IRQ_P1_FALL] = irq_stat_next[IRQ_P1_FALL] | f_evt1;
    irq_stat_next[IRQ_P2_RISE] = irq_stat_next[IRQ_P2_RISE] | r_evt2;
    irq_stat_next[IRQ_P2_FALL] = irq_stat_next[IRQ_P2_FALL] | f_evt2;
    ack_next   = rd_take;
    rdata_next = rd_take ? rd_mux : rdata_reg;
    enc_next   = prec_reg ? 2'h0 : enc_pulse_in;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg     <= CTRL_RESET;
      prec_reg     <= 1'b0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      rdata_reg    <= '0;
      ack_reg      <= 1'b0;
      enc_reg      <= 2'h0;
    end else begin
      ctrl_reg     <= ctrl_next;
      prec_reg     <= prec_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      rdata_reg    <= rdata_next;
      ack_reg      <= ack_next;
      enc_reg      <= enc_next;
    end
  end

  assign avs_waitrequest_out = avs_read_in & ~ack_reg;
  assign avs_readdata_out    = rdata_reg;
  assign enc_pulse_out       = enc_reg;
  assign irq_out             = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int FINE_GAP = 50;
  logic [TICK_W-1:0] gap_reg;
  logic              seen_reg;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap_reg  <= '0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg  <= normal_tick ? '0 : gap_reg + 1'b1;
      seen_reg <= seen_reg | normal_tick;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  normal_rate_a: assert property (normal_tick && seen_reg |-> gap_reg == TICK_W'(NORMAL_TICK_CYC - 1))
    else $error("normal sampling gap wrong");
  fine_rate_a: assert property (fine_tick |-> ##FINE_GAP fine_tick)
    else $error("fine sampling gap wrong");
  fine_route_a: assert property (prec_reg && fine_tick |-> p2_rise_tick)
    else $error("fine tick not routed to probe two");
  enc_gate_a: assert property (prec_reg |=> enc_pulse_out == 2'h0)
    else $error("encoder output not gated");
  p2_layout_a: assert property (stat2.en |-> $past(ctrl_reg[PROBE_TWO_LSB]))
    else $error("probe two enable misplaced");
  sync_delay_a: assert property ($rose(probe_input_one_in) ##1 probe_input_one_in |=> $rose(probe_sync[0]))
    else $error("probe one synchroniser delay wrong");
  irq_set_a: assert property (r_evt1 |=> irq_stat_reg[IRQ_P1_RISE])
    else $error("capture event lost from status");
  read_answer_a: assert property (avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("read answer late");

  p1_rise_c: cover property (r_evt1 ##[1:1000] f_evt1);
  p2_fine_c: cover property (prec_reg && r_evt2);
  irq_c: cover property ($rose(irq_out));

endmodule
`default_nettype wire

// ### rtl/ppl_pkg.sv
package ppl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int NORMAL_RES_NS   = 55000;
  localparam int FINE_RES_NS     = 2000;
  localparam int MIN_PULSE_NS    = 500000;
  // Resolutions are longest times, so they round down
  localparam int NORMAL_TICK_CYC = (NORMAL_RES_NS / CLK_PERIOD_NS < 1) ? 1 : NORMAL_RES_NS / CLK_PERIOD_NS;
  localparam int FINE_TICK_CYC   = (FINE_RES_NS / CLK_PERIOD_NS < 1) ? 1 : FINE_RES_NS / CLK_PERIOD_NS;
  localparam int TICK_W          = 11;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL     = 6'h00;
  localparam logic [5:0] OFS_STATUS   = 6'h04;
  localparam logic [5:0] OFS_POS1_R   = 6'h08;
  localparam logic [5:0] OFS_POS1_F   = 6'h0C;
  localparam logic [5:0] OFS_POS2_R   = 6'h10;
  localparam logic [5:0] OFS_POS2_F   = 6'h14;
  localparam logic [5:0] OFS_CONFIG   = 6'h18;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h1C;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h20;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          PROBE_TWO_LSB = 8;
  localparam logic [15:0] CTRL_WMASK    = 16'h3737;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam int          CFG_PREC_BIT  = 0;
  localparam int          IRQ_W         = 4;
  localparam int          IRQ_P1_RISE   = 0;
  localparam int          IRQ_P1_FALL   = 1;
  localparam int          IRQ_P2_RISE   = 2;
  localparam int          IRQ_P2_FALL   = 3;

  typedef struct packed {
    logic fall_en;
    logic rise_en;
    logic rsv;
    logic trig_sel;
    logic cont;
    logic en;
  } ppl_ctrl_type;

  typedef struct packed {
    logic fall_st;
    logic rise_st;
    logic en;
  } ppl_stat_type;

  typedef struct packed {
    logic [31:0] rise_pos;
    logic [31:0] fall_pos;
  } ppl_pos_type;

endpackage

// ### rtl/ppl_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ppl_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds the second stage only
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule
`default_nettype wire

// ### rtl/ppl_probe_chan.sv
`timescale 1ns/100ps
`default_nettype none
module ppl_probe_chan
  import ppl_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire ppl_ctrl_type ctrl_in,
  input  wire logic         probe_lvl_in,
  input  wire logic         rise_tick_in,
  input  wire logic         fall_tick_in,
  input  wire logic [31:0]  position_in,
  output ppl_stat_type      stat_out,
  output ppl_pos_type       pos_out,
  output logic              rise_evt_out,
  output logic              fall_evt_out
);

  logic         prev_r_reg, prev_r_next;
  logic         prev_f_reg, prev_f_next;
  ppl_stat_type stat_reg, stat_next;
  ppl_pos_type  pos_reg, pos_next;
  logic         rise_edge, fall_edge, rise_arm, fall_arm, rise_cap, fall_cap;

  always_comb begin
    rise_edge   = rise_tick_in & probe_lvl_in & ~prev_r_reg;
    fall_edge   = fall_tick_in & ~probe_lvl_in & prev_f_reg;
    prev_r_next = rise_tick_in ? probe_lvl_in : prev_r_reg;
    prev_f_next = fall_tick_in ? probe_lvl_in : prev_f_reg;
    rise_arm    = ctrl_in.en & ctrl_in.rise_en;
    fall_arm    = ctrl_in.en & ctrl_in.fall_en;
    // Single mode keeps the first edge until re-armed
    rise_cap    = rise_arm & rise_edge & (ctrl_in.cont | ~stat_reg.rise_st);
    fall_cap    = fall_arm & fall_edge & (ctrl_in.cont | ~stat_reg.fall_st);
    stat_next.en      = ctrl_in.en;
    stat_next.rise_st = rise_arm & (stat_reg.rise_st | rise_cap);
    stat_next.fall_st = fall_arm & (stat_reg.fall_st | fall_cap);
    pos_next          = pos_reg;
    if (rise_cap) begin
      pos_next.rise_pos = position_in;
    end
    if (fall_cap) begin
      pos_next.fall_pos = position_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_r_reg <= 1'b0;
      prev_f_reg <= 1'b0;
      stat_reg   <= '0;
      pos_reg    <= '0;
    end else begin
      prev_r_reg <= prev_r_next;
      prev_f_reg <= prev_f_next;
      stat_reg   <= stat_next;
      pos_reg    <= pos_next;
    end
  end

  assign stat_out     = stat_reg;
  assign pos_out      = pos_reg;
  assign rise_evt_out = rise_cap;
  assign fall_evt_out = fall_cap;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  rise_capture_a: assert property (rise_cap |=> stat_reg.rise_st && pos_reg.rise_pos == $past(position_in))
    else $error("rising capture lost");
  fall_capture_a: assert property (fall_cap |=> stat_reg.fall_st && pos_reg.fall_pos == $past(position_in))
    else $error("falling capture lost");
  rise_stop_a: assert property (ctrl_in.en && !ctrl_in.rise_en |=> !stat_reg.rise_st && $stable(pos_reg.rise_pos))
    else $error("rising stop misbehaves");
  rearm_hold_a: assert property ($rose(ctrl_in.rise_en) && !rise_edge |=> $stable(pos_reg.rise_pos))
    else $error("re-arm altered held position");
  disable_clear_a: assert property (!ctrl_in.en |=> stat_reg == '0 ##0 $stable(pos_reg))
    else $error("disable did not clear flags");
  single_hold_a: assert property (stat_reg.rise_st && !ctrl_in.cont |=> $stable(pos_reg.rise_pos))
    else $error("single mode overwrote");
  enable_flag_a: assert property ($rose(ctrl_in.en) |=> stat_reg.en [*1])
    else $error("enable flag not raised");

  cont_cover_c: cover property (rise_cap && ctrl_in.cont && stat_reg.rise_st);

endmodule
`default_nettype wire

// ### testbench/ppl_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
module ppl_sensor_model
  import ppl_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic [1:0] want_in,
  output logic      [1:0] probe_out
);
  // ----------------------------------------------------------------
  // Level hold per probe line
  // ----------------------------------------------------------------
  localparam int HOLD_CYC = MIN_PULSE_NS / CLK_PERIOD_NS;
  int held [2];
  // An early request is delayed, never dropped, so every edge stays legal
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      probe_out <= 2'h0;
      held      <= '{HOLD_CYC, HOLD_CYC};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (want_in[i] != probe_out[i] && held[i] >= HOLD_CYC) begin
          probe_out[i] <= want_in[i];
          held[i]      <= 1;
        end else if (held[i] < HOLD_CYC) begin
          held[i] <= held[i] + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/ppl_probe_latch_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ppl_probe_latch_tb
  import ppl_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int CAP  = NORMAL_TICK_CYC + 8;
  localparam int FINE = FINE_TICK_CYC + 8;
  logic        clk_in = 1'b0;
  logic        resetn_in;
  logic [5:0]  bus_addr;
  logic        bus_rd;
  logic        bus_wr;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic        bus_wait;
  logic [1:0]  probe_want;
  logic [1:0]  probe_lvl;
  logic [31:0] position;
  logic [1:0]  enc_in;
  logic [1:0]  enc_out;
  logic        irq;
  int          miscompares;
  int          checks_done;

  always #20 clk_in = ~clk_in;

  ppl_probe_latch dut (
    .clk_in              (clk_in),
    .resetn_in           (resetn_in),
    .avs_address_in      (bus_addr),
    .avs_read_in         (bus_rd),
    .avs_write_in        (bus_wr),
    .avs_writedata_in    (bus_wdata),
    .avs_byteenable_in   (4'hF),
    .avs_readdata_out    (bus_rdata),
    .avs_waitrequest_out (bus_wait),
    .probe_input_one_in  (probe_lvl[0]),
    .probe_input_two_in  (probe_lvl[1]),
    .position_in         (position),
    .enc_pulse_in        (enc_in),
    .enc_pulse_out       (enc_out),
    .irq_out             (irq)
  );

  ppl_sensor_model sensor (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .want_in   (probe_want),
    .probe_out (probe_lvl)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The answer time is never assumed; only the bound cuts a hung wait
  task automatic bus_op(input logic rd, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    bus_addr  <= a;
    bus_rd    <= rd;
    bus_wr    <= !rd;
    bus_wdata <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (bus_wait !== 1'b0 && n < 50);
    q = bus_rdata;
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    if (n >= 50) miscompares++;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_op(1'b0, a, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus_op(1'b1, a, 32'h0, q);
    check(nm, q, e);
  endtask

  task automatic probe(input int i, input logic lv, input logic [31:0] p, input int cyc);
    int n;
    n = 0;
    @(posedge clk_in);
    position      <= p;
    probe_want[i] <= lv;
    while (probe_lvl[i] !== lv && n < 20000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 20000) miscompares++;
    repeat (cyc) @(posedge clk_in);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset_map();
    for (int k = 0; k < 10; k++) begin
      rd_chk("reset value", 6'(k * 4), 32'h0);
    end
    wr(OFS_CTRL, 32'hFFFF_FFFF);
    rd_chk("ctrl bits", OFS_CTRL, {16'h0, CTRL_WMASK});
    rd_chk("both enabled", OFS_STATUS, 32'h0000_0101);
    wr(OFS_CTRL, 32'h0);
    rd_chk("both disabled", OFS_STATUS, 32'h0);
  endtask

  task automatic sc_probe1_edges();
    wr(OFS_CTRL, 32'h0000_0031);
    rd_chk("p1 armed", OFS_STATUS, 32'h1);
    probe(0, 1'b1, 32'h1234_5678, CAP);
    rd_chk("p1 rise flag", OFS_STATUS, 32'h3);
    rd_chk("p1 rise pos", OFS_POS1_R, 32'h1234_5678);
    rd_chk("irq status", OFS_IRQ_STAT, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    @(posedge clk_in);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    @(posedge clk_in);
    check("irq cleared", {31'h0, irq}, 32'h0);
    probe(0, 1'b0, 32'hA5A5_0F0F, CAP);
    rd_chk("p1 fall flag", OFS_STATUS, 32'h7);
    rd_chk("p1 fall pos", OFS_POS1_F, 32'hA5A5_0F0F);
    check("fall masked", {31'h0, irq}, 32'h0);
  endtask

  task automatic sc_single_rearm();
    probe(0, 1'b1, 32'h0BAD_0001, CAP);
    rd_chk("single keeps", OFS_POS1_R, 32'h1234_5678);
    wr(OFS_CTRL, 32'h0000_0021);
    rd_chk("rise off flag", OFS_STATUS, 32'h5);
    rd_chk("rise off pos", OFS_POS1_R, 32'h1234_5678);
    wr(OFS_CTRL, 32'h0000_0033);
    rd_chk("rearm pos", OFS_POS1_R, 32'h1234_5678);
    probe(0, 1'b0, 32'h0000_0C0D, CAP);
    rd_chk("cont overwrite", OFS_POS1_F, 32'h0000_0C0D);
    probe(0, 1'b1, 32'h7FFF_FFFF, CAP);
    rd_chk("rearm capture", OFS_POS1_R, 32'h7FFF_FFFF);
    rd_chk("rearm flags", OFS_STATUS, 32'h7);
    wr(OFS_CTRL, 32'h0);
    rd_chk("off flags", OFS_STATUS, 32'h0);
    rd_chk("off rise pos", OFS_POS1_R, 32'h7FFF_FFFF);
    rd_chk("off fall pos", OFS_POS1_F, 32'h0000_0C0D);
  endtask

  task automatic sc_probe2_fine();
    enc_in <= 2'b10;
    repeat (3) @(posedge clk_in);
    check("enc pass", {30'h0, enc_out}, 32'h2);
    wr(OFS_CONFIG, 32'h1);
    repeat (2) @(posedge clk_in);
    check("enc off", {30'h0, enc_out}, 32'h0);
    wr(OFS_CTRL, 32'h0000_3100);
    rd_chk("p2 armed", OFS_STATUS, 32'h0000_0100);
    probe(1, 1'b1, 32'h0055_AA00, FINE);
    rd_chk("p2 fine flag", OFS_STATUS, 32'h0000_0300);
    rd_chk("p2 fine pos", OFS_POS2_R, 32'h0055_AA00);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    resetn_in  = 1'b0;
    bus_addr   = 6'h00;
    bus_rd     = 1'b0;
    bus_wr     = 1'b0;
    bus_wdata  = 32'h0;
    probe_want = 2'h0;
    position   = 32'h0;
    enc_in     = 2'h0;
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    sc_reset_map();
    sc_probe1_edges();
    sc_single_rearm();
    sc_probe2_fine();
    tally_and_finish();
  end

  // Six probe edges, four of them held 12500 cycles apart, need about 52000 cycles
  initial begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
